//--- rtl/dis_pkg.sv
package dis_pkg;

    // one-hot protocol states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_CMD   = 7'h04,
        ST_WDATA = 7'h08,
        ST_RDATA = 7'h10,
        ST_GC    = 7'h20,
        ST_HOLD  = 7'h40
    } dis_state_e;

    // bit slot numbering inside one byte frame
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;

    // address byte layout
    localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h60;

    // general call command bytes
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [7:0] GC_CMD_WAKE = 8'h0a;

    // command byte layout: register address, code high, code low, hv
    localparam int CMD_REG_MSB = 7;
    localparam int CMD_REG_LSB = 3;
    localparam int CMD_CODE_HIGH_POS = 2;
    localparam int CMD_CODE_LOW_POS = 1;
    localparam int CMD_HV_POS = 0;
    localparam logic [1:0] CMD_CODE_WRITE = 2'h0;
    localparam logic [1:0] CMD_CODE_READ = 2'h3;

    localparam int REG_ADDR_W = 5;
    localparam int DATA_W = 16;

    // reset values
    localparam logic [4:0] REG_ADDR_RESET = 5'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : dis_pkg

//--- rtl/dis_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dis_link_if;
    logic bitToggle;
    logic bitValue;

    modport link (output bitToggle, output bitValue);
    modport core (input bitToggle, input bitValue);
endinterface : dis_link_if

`default_nettype wire

//--- rtl/dis_link_sampler.sv
`timescale 1ns/1ps
`default_nettype none

// samples the data line on each rising serial clock edge and flips a
// toggle so the core domain sees one event per bit
module dis_link_sampler (
    input wire logic sclClk,
    input wire logic reset,
    input wire logic sdaIn,
    dis_link_if.link bits
);

    logic toggle_q;
    logic value_q;

    always_ff @(posedge sclClk or posedge reset) begin
        if (reset) begin
            toggle_q <= 1'b0;
            value_q <= 1'b1;
        end else begin
            toggle_q <= ~toggle_q;
            value_q <= sdaIn;
        end
    end

    assign bits.bitToggle = toggle_q;
    assign bits.bitValue = value_q;

endmodule : dis_link_sampler

`default_nettype wire

//--- rtl/dis_slave.sv
`timescale 1ns/1ps
`default_nettype none

module dis_slave #(
    parameter logic [6:0] DEV_ADDR = dis_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic sclClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic writeStrobe,
    output logic [4:0] writeAddr,
    output logic [15:0] writeData,
    output logic [4:0] readAddr,
    input wire logic [15:0] readData,
    output logic gcReset,
    output logic gcWake
);

    dis_link_if linkBits ();

    dis_link_sampler uSampler (
        .sclClk(sclClk),
        .reset(reset),
        .sdaIn(sdaIn),
        .bits(linkBits)
    );

    // pin and toggle synchronisers; third stage only for edge detection
    logic sclA_q, sclS_q, sclP_q;
    logic sdaA_q, sdaS_q, sdaP_q;
    logic togA_q, togS_q, togP_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sclA_q <= 1'b1;
            sclS_q <= 1'b1;
            sclP_q <= 1'b1;
            sdaA_q <= 1'b1;
            sdaS_q <= 1'b1;
            sdaP_q <= 1'b1;
            togA_q <= 1'b0;
            togS_q <= 1'b0;
            togP_q <= 1'b0;
        end else begin
            sclA_q <= sclIn;
            sclS_q <= sclA_q;
            sclP_q <= sclS_q;
            sdaA_q <= sdaIn;
            sdaS_q <= sdaA_q;
            sdaP_q <= sdaS_q;
            togA_q <= linkBits.bitToggle;
            togS_q <= togA_q;
            togP_q <= togS_q;
        end
    end

    logic startEv, stopEv, sclFall, bitEv, bitVal;
    assign startEv = sclS_q & sdaP_q & ~sdaS_q;
    assign stopEv = sclS_q & ~sdaP_q & sdaS_q;
    assign sclFall = sclP_q & ~sclS_q;
    assign bitEv = togS_q ^ togP_q;
    // held by the sampler for a whole bit period, stable once bitEv fires
    assign bitVal = linkBits.bitValue;

    dis_pkg::dis_state_e state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic ackWanted_q;
    logic rdLow_q;
    logic wrLow_q;
    logic [7:0] hiByte_q;
    logic [4:0] regAddr_q;
    logic [4:0] lastAddr_q;
    logic pending_q;
    logic [4:0] pendAddr_q;
    logic [15:0] pendData_q;

    logic byteDone;
    logic [7:0] newByte;
    logic [1:0] cmdCode;
    logic addrHit;
    logic commitNow;

    assign newByte = {shift_q[6:0], bitVal};
    assign byteDone = bitEv && (bitCnt_q == dis_pkg::BIT_LAST_DATA)
        && (state_q != dis_pkg::ST_IDLE);
    assign cmdCode = {newByte[dis_pkg::CMD_CODE_HIGH_POS],
                      newByte[dis_pkg::CMD_CODE_LOW_POS]};
    assign addrHit = (newByte[7:1] == DEV_ADDR);
    assign commitNow = pending_q && (stopEv ||
        (byteDone && state_q == dis_pkg::ST_CMD));

    // protocol state; start and stop clear only this state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= dis_pkg::ST_IDLE;
            bitCnt_q <= dis_pkg::BIT_CNT_RESET;
            shift_q <= dis_pkg::BYTE_RESET;
            tx_q <= dis_pkg::BYTE_RESET;
            ackWanted_q <= 1'b0;
            rdLow_q <= 1'b0;
            wrLow_q <= 1'b0;
            hiByte_q <= dis_pkg::BYTE_RESET;
            regAddr_q <= dis_pkg::REG_ADDR_RESET;
            lastAddr_q <= dis_pkg::REG_ADDR_RESET;
            pending_q <= 1'b0;
            pendAddr_q <= dis_pkg::REG_ADDR_RESET;
            pendData_q <= dis_pkg::DATA_RESET;
        end else if (startEv) begin
            state_q <= dis_pkg::ST_ADDR;
            bitCnt_q <= dis_pkg::BIT_CNT_RESET;
            ackWanted_q <= 1'b0;
            pending_q <= 1'b0;
        end else if (stopEv) begin
            state_q <= dis_pkg::ST_IDLE;
            bitCnt_q <= dis_pkg::BIT_CNT_RESET;
            ackWanted_q <= 1'b0;
            pending_q <= 1'b0;
        end else if (bitEv && state_q != dis_pkg::ST_IDLE) begin
            if (bitCnt_q == dis_pkg::BIT_ACK_SLOT) begin
                bitCnt_q <= dis_pkg::BIT_CNT_RESET;
                ackWanted_q <= 1'b0;
                if (state_q == dis_pkg::ST_RDATA) begin
                    if (!ackWanted_q && bitVal) begin
                        state_q <= dis_pkg::ST_IDLE;
                    end else begin
                        tx_q <= rdLow_q ? readData[7:0] : readData[15:8];
                        rdLow_q <= ~rdLow_q;
                    end
                end
            end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                shift_q <= newByte;
                if (bitCnt_q == dis_pkg::BIT_LAST_DATA) begin
                    case (state_q)
                        dis_pkg::ST_ADDR: begin
                            if (addrHit && newByte[0]) begin
                                state_q <= dis_pkg::ST_RDATA;
                                rdLow_q <= 1'b0;
                                ackWanted_q <= 1'b1;
                            end else if (addrHit) begin
                                state_q <= dis_pkg::ST_CMD;
                                ackWanted_q <= 1'b1;
                            end else if (newByte ==
                                         dis_pkg::GENERAL_CALL_ADDR) begin
                                state_q <= dis_pkg::ST_GC;
                                ackWanted_q <= 1'b1;
                            end else begin
                                state_q <= dis_pkg::ST_HOLD;
                            end
                        end
                        dis_pkg::ST_CMD: begin
                            // hv bit does not take part in decoding
                            pending_q <= 1'b0;
                            if (cmdCode == dis_pkg::CMD_CODE_WRITE) begin
                                regAddr_q <= newByte[dis_pkg::CMD_REG_MSB:
                                                     dis_pkg::CMD_REG_LSB];
                                state_q <= dis_pkg::ST_WDATA;
                                wrLow_q <= 1'b0;
                                ackWanted_q <= 1'b1;
                            end else if (cmdCode ==
                                         dis_pkg::CMD_CODE_READ) begin
                                lastAddr_q <= newByte[dis_pkg::CMD_REG_MSB:
                                                      dis_pkg::CMD_REG_LSB];
                                state_q <= dis_pkg::ST_HOLD;
                                ackWanted_q <= 1'b1;
                            end else begin
                                state_q <= dis_pkg::ST_HOLD;
                            end
                        end
                        dis_pkg::ST_WDATA: begin
                            ackWanted_q <= 1'b1;
                            wrLow_q <= ~wrLow_q;
                            if (!wrLow_q) begin
                                hiByte_q <= newByte;
                            end else begin
                                pendData_q <= {hiByte_q, newByte};
                                pendAddr_q <= regAddr_q;
                                pending_q <= 1'b1;
                                state_q <= dis_pkg::ST_CMD;
                            end
                        end
                        dis_pkg::ST_GC: begin
                            ackWanted_q <= (newByte == dis_pkg::GC_CMD_RESET)
                                || (newByte == dis_pkg::GC_CMD_WAKE);
                            state_q <= dis_pkg::ST_HOLD;
                        end
                        default: begin
                            state_q <= state_q;
                        end
                    endcase
                end
            end
        end
    end

    // data line drive: ack in slot nine, read bits in ST_RDATA, released otherwise
    logic sdaOe_q;
    logic sdaOut_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sdaOe_q <= 1'b0;
            sdaOut_q <= 1'b0;
        end else if (startEv || stopEv) begin
            sdaOe_q <= 1'b0;
        end else if (sclFall) begin
            if (bitCnt_q == dis_pkg::BIT_ACK_SLOT) begin
                sdaOe_q <= ackWanted_q;
            end else if (state_q == dis_pkg::ST_RDATA) begin
                sdaOe_q <= ~tx_q[3'h7 - bitCnt_q[2:0]];
            end else begin
                sdaOe_q <= 1'b0;
            end
        end
    end

    // user-side outputs
    logic writeStrobe_q;
    logic [4:0] writeAddr_q;
    logic [15:0] writeData_q;
    logic gcReset_q;
    logic gcWake_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            writeStrobe_q <= 1'b0;
            writeAddr_q <= dis_pkg::REG_ADDR_RESET;
            writeData_q <= dis_pkg::DATA_RESET;
            gcReset_q <= 1'b0;
            gcWake_q <= 1'b0;
        end else begin
            writeStrobe_q <= commitNow;
            if (commitNow) begin
                writeAddr_q <= pendAddr_q;
                writeData_q <= pendData_q;
            end
            gcReset_q <= byteDone && state_q == dis_pkg::ST_GC
                && newByte == dis_pkg::GC_CMD_RESET;
            gcWake_q <= byteDone && state_q == dis_pkg::ST_GC
                && newByte == dis_pkg::GC_CMD_WAKE;
        end
    end

    assign sdaOut = sdaOut_q;
    assign sdaOe = sdaOe_q;
    assign writeStrobe = writeStrobe_q;
    assign writeAddr = writeAddr_q;
    assign writeData = writeData_q;
    assign readAddr = lastAddr_q;
    assign gcReset = gcReset_q;
    assign gcWake = gcWake_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_one_pulse(sig);
        sig ##1 !sig;
    endsequence

    property p_addr_write;
        byteDone && state_q == dis_pkg::ST_ADDR && addrHit && !newByte[0]
            |=> state_q == dis_pkg::ST_CMD && ackWanted_q;
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("write address not acknowledged");

    property p_word_repeat;
        byteDone && state_q == dis_pkg::ST_WDATA && wrLow_q
            |=> state_q == dis_pkg::ST_CMD && pending_q
                && pendData_q == {hiByte_q, $past(newByte)};
    endproperty
    a_word_repeat: assert property (p_word_repeat)
        else $error("write word not held for continuous mode");

    property p_read_cmd;
        byteDone && state_q == dis_pkg::ST_CMD
            && cmdCode == dis_pkg::CMD_CODE_READ
            |=> state_q == dis_pkg::ST_HOLD && ackWanted_q;
    endproperty
    a_read_cmd: assert property (p_read_cmd)
        else $error("read command not accepted");

    property p_hv_write;
        byteDone && state_q == dis_pkg::ST_CMD
            && cmdCode == dis_pkg::CMD_CODE_WRITE
            |=> state_q == dis_pkg::ST_WDATA
                && regAddr_q == $past(newByte[7:3]);
    endproperty
    a_hv_write: assert property (p_hv_write)
        else $error("write command refused");

    property p_gc_reset;
        byteDone && state_q == dis_pkg::ST_GC
            && newByte == dis_pkg::GC_CMD_RESET
            |=> s_one_pulse(gcReset) and ackWanted_q;
    endproperty
    a_gc_reset: assert property (p_gc_reset)
        else $error("general call reset not pulsed");

    property p_keep_data;
        (startEv || stopEv) && !pending_q
            |=> $stable(writeData_q) && $stable(lastAddr_q);
    endproperty
    a_keep_data: assert property (p_keep_data)
        else $error("interface reset disturbed stored data");

    property p_start_restart;
        startEv |=> state_q == dis_pkg::ST_ADDR && bitCnt_q == 4'h0
            && !sdaOe_q;
    endproperty
    a_start_restart: assert property (p_start_restart)
        else $error("start did not restart the slave");

    property p_nack_reset;
        bitEv && state_q == dis_pkg::ST_RDATA && !startEv && !stopEv
            && bitCnt_q == dis_pkg::BIT_ACK_SLOT && !ackWanted_q && bitVal
            |=> state_q == dis_pkg::ST_IDLE;
    endproperty
    a_nack_reset: assert property (p_nack_reset)
        else $error("master nack did not reset the slave");

    property p_commit_stop;
        stopEv && pending_q
            |=> writeStrobe && writeData == $past(pendData_q) ##1 !writeStrobe;
    endproperty
    a_commit_stop: assert property (p_commit_stop)
        else $error("pending write not committed on stop");

    property p_abort_start;
        startEv |=> !pending_q ##1 !writeStrobe;
    endproperty
    a_abort_start: assert property (p_abort_start)
        else $error("start did not abort pending write");

    property p_idle_quiet;
        state_q == dis_pkg::ST_IDLE && !startEv
            |=> state_q == dis_pkg::ST_IDLE && !sdaOe_q;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("slave left idle without a start");

endmodule : dis_slave

`default_nettype wire

//--- tb/dis_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// bus master at standard rate; no speed-mode entry is used
module dis_master_model (
    output logic scl,
    output wire logic sda,
    input wire logic slaveOe
);
    logic pullLow = 1'b0;
    int bitCount = 0;

    initial scl = 1'b1;
    // pull-up: a released line reads high
    assign sda = ~(pullLow | slaveOe);

    // start from idle, or repeated start mid-frame
    task automatic startCond;
        pullLow = 1'b0;
        #60;
        scl = 1'b1;
        #80;
        pullLow = 1'b1;
        #80;
        scl = 1'b0;
        bitCount++;
    endtask : startCond

    // clock is left high so it stands still until the next frame
    task automatic stopCond;
        pullLow = 1'b1;
        #60;
        scl = 1'b1;
        #80;
        pullLow = 1'b0;
        #80;
        bitCount++;
    endtask : stopCond

    // one slot: data changes only while the clock is low
    task automatic clockBit(input logic b, output logic got);
        #20;
        pullLow = ~b;
        #60;
        scl = 1'b1;
        #40;
        got = sda;
        #40;
        scl = 1'b0;
        bitCount++;
    endtask : clockBit

    task automatic xferByte(input logic [7:0] tx, input logic ackBit,
            output logic [7:0] rx, output logic acked);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            clockBit(tx[i], got);
            rx[i] = got;
        end
        clockBit(ackBit, got);
        acked = ~got;
    endtask : xferByte

    // clocks a byte with no start before it
    task automatic noiseByte(input logic [7:0] tx, output logic acked);
        logic [7:0] r;
        #40;
        scl = 1'b0;
        xferByte(tx, 1'b1, r, acked);
    endtask : noiseByte

    // start, nine released ones, start, stop
    task automatic recover;
        logic got;
        startCond();
        repeat (9) clockBit(1'b1, got);
        startCond();
        stopCond();
    endtask : recover
endmodule : dis_master_model

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [7:0] ADDR_W = 8'hc0;
    localparam logic [7:0] ADDR_R = 8'hc1;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [15:0] readData = 16'h5a3c;
    wire logic scl;
    wire logic sda;
    logic sdaOut;
    logic sdaOe;
    logic writeStrobe;
    logic [4:0] writeAddr;
    logic [15:0] writeData;
    logic [4:0] readAddr;
    logic gcReset;
    logic gcWake;
    logic bitGot;
    logic ack;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int strobes = 0;
    int resets = 0;
    int wakes = 0;
    logic [4:0] lastAddr = 5'h00;
    logic [15:0] lastData = 16'h0000;

    always #5 clock = ~clock;

    dis_slave #(.DEV_ADDR(7'h60)) dis_slave_inst (
        .clock(clock), .reset(reset), .sclClk(scl), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .writeStrobe(writeStrobe), .writeAddr(writeAddr),
        .writeData(writeData), .readAddr(readAddr),
        .readData(readData), .gcReset(gcReset), .gcWake(gcWake)
    );

    dis_master_model dis_master_model_inst (
        .scl(scl), .sda(sda), .slaveOe(sdaOe && (sdaOut === 1'b0))
    );

    always @(posedge clock) begin
        cycles++;
        if (writeStrobe === 1'b1) begin
            strobes++;
            lastAddr = writeAddr;
            lastData = writeData;
        end
        if (gcReset === 1'b1) resets++;
        if (gcWake === 1'b1) wakes++;
        if (cycles == 40000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic checkValue(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : checkValue

    task automatic checkFlag(input logic got, input logic exp);
        checkValue({15'h0000, got}, {15'h0000, exp});
    endtask : checkFlag

    task automatic beginFrame(input logic [15:0] rd);
        @(posedge clock);
        #1;
        readData = rd;
        strobes = 0;
        resets = 0;
        wakes = 0;
        dis_master_model_inst.bitCount = 0;
        dis_master_model_inst.startCond();
    endtask : beginFrame

    task automatic endFrame(input int exp);
        dis_master_model_inst.stopCond();
        checkValue(16'(dis_master_model_inst.bitCount), 16'(exp));
        repeat (10) @(posedge clock);
        #1;
    endtask : endFrame

    task automatic sendByte(input logic [7:0] value, input logic expAck);
        logic [7:0] rx;
        logic a;
        dis_master_model_inst.xferByte(value, 1'b1, rx, a);
        checkFlag(a, expAck);
    endtask : sendByte

    task automatic recvByte(input logic ackBit, input logic [7:0] exp);
        logic [7:0] rx;
        logic a;
        dis_master_model_inst.xferByte(8'hff, ackBit, rx, a);
        checkValue({8'h00, rx}, {8'h00, exp});
    endtask : recvByte

    task automatic testSingleWrite;
        beginFrame(readData);
        sendByte(ADDR_W, 1'b1);
        sendByte(8'h28, 1'b1);
        sendByte(8'h12, 1'b1);
        sendByte(8'h34, 1'b1);
        endFrame(38);
        checkFlag(strobes == 1, 1'b1);
        checkValue({11'h000, lastAddr}, 16'h0005);
        checkValue(lastData, 16'h1234);
    endtask : testSingleWrite

    task automatic testContinuousWrite;
        beginFrame(readData);
        sendByte(ADDR_W, 1'b1);
        sendByte(8'h30, 1'b1);
        sendByte(8'hab, 1'b1);
        sendByte(8'hcd, 1'b1);
        sendByte(8'h39, 1'b1);
        sendByte(8'h01, 1'b1);
        sendByte(8'h02, 1'b1);
        endFrame(65);
        checkFlag(strobes == 2, 1'b1);
        checkValue({11'h000, lastAddr}, 16'h0007);
        checkValue(lastData, 16'h0102);
    endtask : testContinuousWrite

    task automatic testReads;
        for (int hv = 0; hv < 2; hv++) begin
            beginFrame(16'h5a3c);
            sendByte(ADDR_W, 1'b1);
            sendByte({5'h03, 2'h3, hv[0]}, 1'b1);
            dis_master_model_inst.startCond();
            sendByte(ADDR_R, 1'b1);
            recvByte(1'b0, 8'h5a);
            recvByte(1'b1, 8'h3c);
            endFrame(48);
            checkValue({11'h000, readAddr}, 16'h0003);
        end
        beginFrame(16'hc3e1);
        sendByte(ADDR_R, 1'b1);
        for (int i = 0; i < 4; i++) begin
            recvByte(i == 3, i[0] ? 8'he1 : 8'hc3);
        end
        endFrame(47);
        beginFrame(16'h9b07);
        sendByte(ADDR_R, 1'b1);
        recvByte(1'b0, 8'h9b);
        recvByte(1'b1, 8'h07);
        endFrame(29);
    endtask : testReads

    task automatic testGeneralCall;
        logic [7:0] cmds [3] = '{8'h06, 8'h0a, 8'h55};
        for (int i = 0; i < 3; i++) begin
            beginFrame(readData);
            sendByte(8'h00, 1'b1);
            sendByte(cmds[i], i < 2);
            endFrame(20);
            checkFlag(resets == 1, i == 0);
            checkFlag(wakes == 1, i == 1);
            checkFlag(strobes == 0, 1'b1);
        end
    endtask : testGeneralCall

    task automatic testRefusals;
        beginFrame(readData);
        sendByte(8'ha0, 1'b0);
        endFrame(11);
        beginFrame(readData);
        sendByte(ADDR_W, 1'b1);
        sendByte(8'h2a, 1'b0);
        endFrame(20);
        dis_master_model_inst.noiseByte(ADDR_W, ack);
        checkFlag(ack, 1'b0);
        dis_master_model_inst.stopCond();
        repeat (10) @(posedge clock);
        checkFlag(sdaOe, 1'b0);
    endtask : testRefusals

    task automatic testRestart;
        beginFrame(readData);
        sendByte(ADDR_W, 1'b1);
        repeat (3) dis_master_model_inst.clockBit(1'b0, bitGot);
        dis_master_model_inst.startCond();
        sendByte(ADDR_W, 1'b1);
        sendByte(8'h50, 1'b1);
        sendByte(8'hbe, 1'b1);
        sendByte(8'hef, 1'b1);
        endFrame(51);
        checkValue({11'h000, lastAddr}, 16'h000a);
        checkValue(lastData, 16'hbeef);
    endtask : testRestart

    task automatic testRecovery;
        beginFrame(readData);
        sendByte(ADDR_W, 1'b1);
        sendByte(8'h28, 1'b1);
        sendByte(8'h77, 1'b1);
        sendByte(8'h88, 1'b1);
        dis_master_model_inst.recover();
        repeat (10) @(posedge clock);
        checkFlag(strobes == 0, 1'b1);
        beginFrame(16'h00f0);
        sendByte(ADDR_R, 1'b1);
        repeat (4) begin
            dis_master_model_inst.clockBit(1'b1, bitGot);
            checkFlag(bitGot, 1'b0);
        end
        dis_master_model_inst.recover();
        repeat (10) @(posedge clock);
        checkFlag(sdaOe, 1'b0);
        checkFlag(strobes == 0, 1'b1);
        testSingleWrite();
    endtask : testRecovery

    task automatic complete_run;
        $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge clock);
        checkFlag(sdaOe, 1'b0);
        #1;
        // master comes out of its own reset: recover the slave first
        dis_master_model_inst.recover();
        repeat (10) @(posedge clock);
        checkFlag(sdaOe, 1'b0);
        testSingleWrite();
        testContinuousWrite();
        testReads();
        testGeneralCall();
        testRefusals();
        testRestart();
        testRecovery();
        complete_run();
    end
endmodule : testbench

`default_nettype wire
